// file: pkg/dacr_pkg.sv
`default_nettype none
package dacr_pkg;
	// Byte addresses of the register words
	localparam logic [7:0] OFS_CTRL0     = 8'h00;
	localparam logic [7:0] OFS_CTRL1     = 8'h04;
	localparam logic [7:0] OFS_COMMON    = 8'h08;
	localparam logic [7:0] OFS_TRIG0     = 8'h0C;
	localparam logic [7:0] OFS_TRIG1     = 8'h10;
	localparam logic [7:0] OFS_RES0      = 8'h14;
	localparam logic [7:0] OFS_RES1      = 8'h18;
	localparam logic [7:0] OFS_CAP       = 8'h1C;
	localparam logic [7:0] OFS_FLAGS     = 8'h20;
	// Per-converter control word fields
	localparam int         CTL_ON        = 0;
	localparam int         CTL_GO        = 1;
	localparam int         CTL_DS        = 2;
	// Common control fields
	localparam int         COM_FM        = 7;
	localparam int         COM_CS_LO     = 4;
	localparam int         COM_NREF      = 3;
	localparam int         COM_GOALL     = 2;
	localparam int         COM_PREF_LO   = 0;
	localparam int         TRG_LO        = 4;
	localparam logic [7:0] TRG_MASK      = 8'h70;
	localparam logic [7:0] COMMON_RST    = 8'h00;
	localparam logic [7:0] TRIG_RST      = 8'h00;
	localparam logic [7:0] CAP_RST       = 8'h00;
	// Trigger codes
	localparam logic [2:0] TRG_NONE      = 3'h0;
	localparam logic [2:0] TRG_TMR4      = 3'h2;
	localparam logic [2:0] TRG_TMR0      = 3'h3;
	localparam logic [2:0] TRG_TMR1      = 3'h4;
	localparam logic [2:0] TRG_TMR2      = 3'h5;
	localparam logic [2:0] TRG_PIN_RISE  = 3'h6;
	localparam logic [2:0] TRG_PIN_FALL  = 3'h7;
	// Conversion: 10 bit periods plus 1 of sampling
	localparam int         CONV_TADS     = 11;
	localparam logic [3:0] CONV_TADS_4   = 4'hB;
	localparam int         INSTR_CYCLES  = 4;
	localparam logic [1:0] INSTR_WAIT    = 2'h3;
	localparam logic [6:0] RC_DIV        = 7'h1F;
	typedef enum logic [1:0] {DACR_IDLE, DACR_WAIT, DACR_CONV} dacr_state_t;
endpackage
`default_nettype wire

// file: core/dacr_core.sv
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module dacr_core
	import dacr_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Trigger sources
	input  wire logic        tmr0_ovf,
	input  wire logic        tmr1_ovf,
	input  wire logic        tmr2_match,
	input  wire logic        tmr4_match,
	input  wire logic        external_trigger_pin,
	// Analog cores: comparator decision per bit period
	input  wire logic [1:0]  sar_cmp,
	// Analog controls
	output logic      [1:0]  converter_enable,
	output logic      [1:0]  mux_connect,
	output logic      [1:0]  sample_hold,
	output logic      [1:0]  bit_tick,
	output logic             negative_reference_select,
	output logic      [1:0]  positive_reference_select,
	output logic      [7:0]  hold_capacitor_trim,
	output logic             hold_discharge,
	// Flags
	output logic      [1:0]  conv_done_flag,
	output logic             tmr0_flag_set,
	output logic             tmr1_flag_set,
	output logic             tmr2_flag_set
);
	logic              wr_q;
	logic [7:0]        wa_q;
	logic [7:0]        common_q;
	logic [7:0]        trig_q     [2];
	logic [7:0]        cap_q;
	logic [1:0]        en_q;
	logic [1:0]        ds_q;
	logic [1:0]        go_q;
	logic [1:0]        done_q;
	logic [9:0]        res_q      [2];
	logic [1:0]        fm_q;
	logic              pin_q;
	logic [6:0]        div_q;
	logic              tad_en;
	logic              wr_en;
	logic [7:0]        wb;
	logic [1:0]        go_wr1;
	logic [1:0]        go_wr0;
	logic [1:0]        trig_evt;
	logic [1:0]        start;
	logic [1:0]        finish;
	logic [1:0]        abort;

	// One-cycle address phase, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
		end else if (hready) begin
			wr_q <= hsel && htrans[1] && hwrite;
			wa_q <= haddr;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_en     = wr_q;
	assign wb        = hwdata[7:0];

	function automatic logic [6:0] div_of(input logic [2:0] cs);
		unique case (cs)
			3'h0: div_of = 7'h00;
			3'h1: div_of = 7'h03;
			3'h2: div_of = 7'h0F;
			3'h4: div_of = 7'h01;
			3'h5: div_of = 7'h07;
			3'h6: div_of = 7'h1F;
			default: div_of = RC_DIV;
		endcase
	endfunction

	function automatic logic is_rc(input logic [2:0] cs);
		is_rc = (cs[1:0] == 2'h3);
	endfunction

	function automatic logic [7:0] res_byte(input logic [9:0] r, input logic fm, input logic hi);
		if (fm)
			res_byte = hi ? {6'h00, r[9:8]} : r[7:0];
		else
			res_byte = hi ? r[9:2] : {r[1:0], 6'h00};
	endfunction

	// Conversion clock divider; RC clock modelled as fixed divide
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_q <= 7'h00;
		else if (div_q >= div_of(common_q[COM_CS_LO +: 3]))
			div_q <= 7'h00;
		else
			div_q <= div_q + 7'h01;
	end
	assign tad_en = (div_q >= div_of(common_q[COM_CS_LO +: 3]));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			common_q <= COMMON_RST;
			cap_q    <= CAP_RST;
		end else if (wr_en) begin
			if (wa_q == OFS_COMMON)
				common_q <= {wb[7:3], 1'b0, wb[1:0]};
			if (wa_q == OFS_CAP)
				cap_q <= wb;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pin_q <= 1'b0;
		else
			pin_q <= external_trigger_pin;
	end

	assign tmr0_flag_set = tmr0_ovf;
	assign tmr1_flag_set = tmr1_ovf;
	assign tmr2_flag_set = tmr2_match;

	generate
		for (genvar c = 0; c < 2; c++) begin : g_conv
			dacr_state_t st_q;
			logic [3:0]  cnt_q;
			logic [1:0]  wt_q;
			logic        pass_q;
			logic [9:0]  sar_q;
			logic        src_q;
			logic        src;

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					trig_q[c] <= TRIG_RST;
				end else if (wr_en && wa_q == (c == 0 ? OFS_TRIG0 : OFS_TRIG1)) begin
					trig_q[c] <= wb & TRG_MASK;
				end
			end

			always_comb begin
				unique case (trig_q[c][TRG_LO +: 3])
					TRG_TMR4:     src = tmr4_match;
					TRG_TMR0:     src = tmr0_ovf;
					TRG_TMR1:     src = tmr1_ovf;
					TRG_TMR2:     src = tmr2_match;
					TRG_PIN_RISE: src = pin_q;
					TRG_PIN_FALL: src = !pin_q;
					default:      src = 1'b0;
				endcase
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					src_q <= 1'b0;
				else
					src_q <= src;
			end
			assign trig_evt[c] = src && !src_q && trig_q[c][TRG_LO +: 3] != TRG_NONE;

			assign go_wr1[c] = wr_en && ((wa_q == (c == 0 ? OFS_CTRL0 : OFS_CTRL1) && wb[CTL_GO])
				|| (wa_q == OFS_COMMON && wb[COM_GOALL]));
			assign go_wr0[c] = wr_en && wa_q == (c == 0 ? OFS_CTRL0 : OFS_CTRL1) && !wb[CTL_GO];
			assign start[c]  = en_q[c] && !go_q[c] && (go_wr1[c] || trig_evt[c]);
			assign abort[c]  = go_q[c] && go_wr0[c] && st_q != DACR_IDLE;
			assign finish[c] = st_q == DACR_CONV && tad_en && cnt_q == 4'h0 && (pass_q || !ds_q[c]);

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					en_q[c] <= 1'b0;
					ds_q[c] <= 1'b0;
				end else if (wr_en && wa_q == (c == 0 ? OFS_CTRL0 : OFS_CTRL1)) begin
					en_q[c] <= wb[CTL_ON];
					ds_q[c] <= wb[CTL_DS];
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					go_q[c] <= 1'b0;
				else if (!en_q[c] || (wr_en && wa_q == (c == 0 ? OFS_CTRL0 : OFS_CTRL1) && !wb[CTL_ON]))
					go_q[c] <= 1'b0;
				else if (start[c])
					go_q[c] <= 1'b1;
				else if (finish[c] || go_wr0[c])
					go_q[c] <= 1'b0;
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					st_q   <= DACR_IDLE;
					cnt_q  <= 4'h0;
					wt_q   <= 2'h0;
					pass_q <= 1'b0;
					sar_q  <= 10'h000;
				end else begin
					unique case (st_q)
						DACR_IDLE: if (start[c]) begin
							wt_q   <= INSTR_WAIT;
							pass_q <= 1'b0;
							sar_q  <= 10'h000;
							cnt_q  <= CONV_TADS_4 - 4'h1;
							st_q   <= is_rc(common_q[COM_CS_LO +: 3]) ? DACR_WAIT : DACR_CONV;
						end
						DACR_WAIT: begin
							if (!go_q[c])
								st_q <= DACR_IDLE;
							else if (wt_q == 2'h0)
								st_q <= DACR_CONV;
							else
								wt_q <= wt_q - 2'h1;
						end
						DACR_CONV: begin
							if (!go_q[c] || abort[c] || !en_q[c]) begin
								st_q <= DACR_IDLE;
							end else if (tad_en) begin
								if (cnt_q < 4'hA)
									sar_q[cnt_q] <= sar_cmp[c];
								if (cnt_q != 4'h0) begin
									cnt_q <= cnt_q - 4'h1;
								end else if (ds_q[c] && !pass_q) begin
									pass_q <= 1'b1;
									cnt_q  <= CONV_TADS_4 - 4'h1;
								end else begin
									st_q <= DACR_IDLE;
								end
							end
						end
					endcase
				end
			end

			// Result loads at completion or abort, holding format at that moment
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					res_q[c] <= 10'h000;
					fm_q[c]  <= 1'b0;
				end else if (finish[c] || abort[c]) begin
					// Last decision lands in the same edge, so take it straight from the core
					res_q[c] <= finish[c] ? {sar_q[9:1], sar_cmp[c]} : sar_q;
					fm_q[c]  <= common_q[COM_FM];
				end
			end

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					done_q[c] <= 1'b0;
				else if (finish[c])
					done_q[c] <= 1'b1;
				else if (wr_en && wa_q == OFS_FLAGS && wb[c])
					done_q[c] <= 1'b0;
			end

			assign sample_hold[c] = en_q[c] && st_q != DACR_CONV;
			assign bit_tick[c]    = st_q == DACR_CONV && tad_en;

			a_go_needs_en: assert property (@(posedge hclk) disable iff (!hresetn)
				!en_q[c] |=> !go_q[c]) else $error("go bit set while converter off");
			a_abort_no_flag: assert property (@(posedge hclk) disable iff (!hresetn)
				abort[c] && !finish[c] |=> $stable(done_q[c])) else $error("abort raised done flag");
			a_trig_sets_go: assert property (@(posedge hclk) disable iff (!hresetn)
				trig_evt[c] && en_q[c] && !go_wr0[c] |=> go_q[c]) else $error("trigger did not set go");
			a_finish_flag: assert property (@(posedge hclk) disable iff (!hresetn)
				finish[c] |=> done_q[c] && !go_q[c]) else $error("completion not flagged");
			a_ds_two_pass: assert property (@(posedge hclk) disable iff (!hresetn)
				st_q == DACR_CONV && tad_en && cnt_q == 4'h0 && ds_q[c] && !pass_q && go_q[c] && en_q[c]
				&& !go_wr0[c] |=> go_q[c]) else $error("double sample ended early");
		end
	endgenerate

	// Read data comes from flops, updated in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			unique case (haddr)
				OFS_CTRL0:  hrdata <= {29'h0, ds_q[0], go_q[0], en_q[0]};
				OFS_CTRL1:  hrdata <= {29'h0, ds_q[1], go_q[1], en_q[1]};
				OFS_COMMON: hrdata <= {24'h0, common_q[7:3], |go_q, common_q[1:0]};
				OFS_TRIG0:  hrdata <= {24'h0, trig_q[0]};
				OFS_TRIG1:  hrdata <= {24'h0, trig_q[1]};
				OFS_RES0:   hrdata <= {16'h0, res_byte(res_q[0], fm_q[0], 1'b1), res_byte(res_q[0], fm_q[0], 1'b0)};
				OFS_RES1:   hrdata <= {16'h0, res_byte(res_q[1], fm_q[1], 1'b1), res_byte(res_q[1], fm_q[1], 1'b0)};
				OFS_CAP:    hrdata <= {24'h0, cap_q};
				OFS_FLAGS:  hrdata <= {30'h0, done_q};
				default:    hrdata <= 32'h0000_0000;
			endcase
		end
	end

	assign converter_enable          = en_q;
	assign mux_connect               = en_q;
	assign negative_reference_select = common_q[COM_NREF];
	assign positive_reference_select = common_q[COM_PREF_LO +: 2];
	assign hold_capacitor_trim       = cap_q;
	assign hold_discharge            = 1'b0;
	assign conv_done_flag            = done_q;

	a_goall_or: assert property (@(posedge hclk) disable iff (!hresetn)
		hready && hsel && htrans[1] && !hwrite && haddr == OFS_COMMON
		|=> hrdata[COM_GOALL] == $past(|go_q)) else $error("sync go not OR of go bits");
	a_sync_start: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_en && wa_q == OFS_COMMON && wb[COM_GOALL] && (&en_q)
		|=> &go_q) else $error("sync go missed a converter");
	a_trig_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		(trig_q[0] & ~TRG_MASK) == 8'h00) else $error("reserved trigger bits set");
endmodule
`default_nettype wire

// file: tb/dacr_far.sv
`timescale 1ns/1ns
`default_nettype none
module dacr_far (
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Converter side
	input  wire logic [1:0] converter_enable,
	input  wire logic [1:0] sample_hold,
	input  wire logic [1:0] cmp_level,
	output logic      [1:0] sar_cmp,
	output logic            acq_ok
);
	logic [3:0] acq_q;
	// A core that is off gives no real decision: show the inverse
	assign sar_cmp = (converter_enable & cmp_level) | (~converter_enable & ~cmp_level);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			acq_q <= 4'h0;
		else if (!sample_hold[0])
			acq_q <= 4'h0;
		else if (acq_q != 4'h8)
			acq_q <= acq_q + 4'h1;
	end
	// Hold capacitor settled after eight sampling cycles
	assign acq_ok = (acq_q == 4'h8);
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import dacr_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pin, acq_ok, hold_discharge, nref;
	logic        tmr0_ovf, tmr1_ovf, tmr2_match, tmr4_match, t0f, t1f, t2f;
	logic [7:0]  haddr, trim, rnd;
	logic [1:0]  htrans, lvl, sar_cmp, cen, mux, sh, tick, pref, done;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	int          err_count, check_count, cyc, n[4];
	assign hready = hreadyout;
	dacr_core dacr_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf),
		.tmr2_match(tmr2_match), .tmr4_match(tmr4_match), .external_trigger_pin(pin), .sar_cmp(sar_cmp),
		.converter_enable(cen), .mux_connect(mux), .sample_hold(sh), .bit_tick(tick),
		.negative_reference_select(nref), .positive_reference_select(pref), .hold_capacitor_trim(trim),
		.hold_discharge(hold_discharge), .conv_done_flag(done), .tmr0_flag_set(t0f), .tmr1_flag_set(t1f),
		.tmr2_flag_set(t2f));
	dacr_far dacr_far_i (.hclk(hclk), .hresetn(hresetn), .converter_enable(cen), .sample_hold(sh),
		.cmp_level(lvl), .sar_cmp(sar_cmp), .acq_ok(acq_ok));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [31:0] exp_res(input logic fm, input logic [9:0] v);
		return fm ? {22'h0, v} : {16'h0, v, 6'h00};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		{hsel, haddr, htrans, hwrite, hsize} <= {1'b1, a, 2'h2, w, 3'h2};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wait_go(input logic [7:0] a, input int b, output int k);
		k = 0;
		do begin
			bus(1'b0, a, 32'h0);
			k++;
		end while (rd[b] !== 1'b0);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, pin, lvl} = '0;
		{tmr0_ovf, tmr1_ovf, tmr2_match, tmr4_match} = '0;
		rnd = 8'h37;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, OFS_COMMON, 32'h0); chk("common reset", 32'h0, rd);
		bus(1'b1, OFS_TRIG0, 32'hFF); bus(1'b0, OFS_TRIG0, 32'h0); chk("trig bits", 32'h70, rd);
		foreach (n[p]) begin
			rnd = lfsr(rnd);
			bus(1'b1, OFS_COMMON, {24'h0, rnd[0], 3'h0, rnd[1], 1'b0, (p == 1) ? 2'h0 : p[1:0]});
			@(negedge hclk);
			chk("nref", rnd[1], nref);
			chk("pref", (p == 1) ? 2'h0 : p[1:0], pref);
		end
		bus(1'b1, OFS_TRIG0, 32'h0);
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			lvl <= rnd[1:0];
			bus(1'b1, OFS_COMMON, {24'h0, k[0], 7'h0});
			bus(1'b1, OFS_CTRL0, {29'h0, k[1], 2'h1});
			while (acq_ok !== 1'b1) @(posedge hclk);
			bus(1'b1, OFS_CTRL0, {29'h0, k[1], 2'h3});
			wait_go(OFS_CTRL0, CTL_GO, n[k]);
			bus(1'b0, OFS_RES0, 32'h0); chk("result", exp_res(k[0], {10{rnd[0]}}), rd);
		end
		chk("double sample", 1'b1, n[3] > n[1] + n[1] / 2);
		chk("done flag", 2'h1, done);
		bus(1'b1, OFS_FLAGS, 32'h3);
		bus(1'b1, OFS_CTRL1, 32'h1);
		bus(1'b1, OFS_CTRL0, 32'h1);
		bus(1'b1, OFS_COMMON, {24'h0, 8'h84});
		bus(1'b0, OFS_COMMON, 32'h0); chk("sync status", 1'b1, rd[COM_GOALL]);
		bus(1'b0, OFS_CTRL1, 32'h0); chk("go1 by sync", 1'b1, rd[CTL_GO]);
		wait_go(OFS_COMMON, COM_GOALL, n[0]);
		chk("both done", 2'h3, done);
		bus(1'b0, OFS_RES1, 32'h0); chk("result1", exp_res(1'b1, {10{lvl[1]}}), rd);
		bus(1'b1, OFS_FLAGS, 32'h3);
		bus(1'b1, OFS_CTRL1, 32'h2);
		bus(1'b0, OFS_CTRL1, 32'h0); chk("go1 off", 32'h0, rd);
		chk("mux1 off", 2'h1, mux);
		chk("enable out", 2'h1, cen);
		bus(1'b1, OFS_COMMON, 32'h04);
		wait_go(OFS_COMMON, COM_GOALL, n[0]);
		chk("only on runs", 2'h1, done);
		bus(1'b1, OFS_FLAGS, 32'h3);
		bus(1'b1, OFS_CTRL0, 32'h3);
		bus(1'b1, OFS_CTRL0, 32'h1);
		bus(1'b0, OFS_CTRL0, 32'h0); chk("abort go", 32'h1, rd);
		chk("abort flag", 2'h0, done);
		rnd = lfsr(rnd);
		bus(1'b1, OFS_CAP, {24'h0, rnd});
		@(negedge hclk);
		chk("cap trim", rnd, trim);
		bus(1'b1, OFS_COMMON, 32'h30);
		bus(1'b1, OFS_CTRL0, 32'h3);
		wait_go(OFS_CTRL0, CTL_GO, n[2]);
		chk("rc clock slow", 1'b1, n[2] > 8 * n[1]);
		for (int c = 2; c < 8; c++) begin
			// Raise the pin with no source selected, so the fall code sees no false edge
			if (c == 7) begin
				bus(1'b1, OFS_TRIG0, 32'h0);
				pin <= 1'b1;
			end
			bus(1'b1, OFS_TRIG0, {25'h0, c[2:0], 4'h0});
			repeat (3) @(posedge hclk);
			{tmr4_match, tmr0_ovf, tmr1_ovf, tmr2_match} <= 4'h1 << (5 - c);
			pin <= (c == 6);
			@(negedge hclk);
			chk("timer flags", {c == 3, c == 4, c == 5}, {t0f, t1f, t2f});
			@(posedge hclk);
			{tmr4_match, tmr0_ovf, tmr1_ovf, tmr2_match} <= 4'h0;
			bus(1'b0, OFS_CTRL0, 32'h0); chk("trigger go", 1'b1, rd[CTL_GO]);
			wait_go(OFS_CTRL0, CTL_GO, n[0]);
			pin <= 1'b0;
		end
		chk("no discharge", 2'h0, {hold_discharge, hresp});
		close_out;
	end
endmodule
`default_nettype wire
